// ---- hdl/dcc_defines.svh ----
// Register offsets, field positions and reset values of the comparator control block.
`ifndef DCC_DEFINES_SVH
`define DCC_DEFINES_SVH

// Byte addresses of the APB registers.
`define DCC_ADDR_CTRL 12'h000
`define DCC_ADDR_FLAG 12'h004
`define DCC_ADDR_EN 12'h008
`define DCC_ADDR_PORT 12'h00c
`define DCC_ADDR_PCFG 12'h010

// Field positions in the comparator_control register.
`define DCC_POS_SECOND_RESULT 7
`define DCC_POS_FIRST_RESULT 6
`define DCC_POS_SECOND_FLIP 5
`define DCC_POS_FIRST_FLIP 4
`define DCC_POS_INPUT_SWITCH 3
`define DCC_POS_MODE_LSB 0

// Field positions in the enable register.
`define DCC_POS_CHANGE_EN 0
`define DCC_POS_PERIPH_EN 1
`define DCC_POS_GLOBAL_EN 2

// Field positions in the port status and port configuration registers.
`define DCC_POS_PORT_E_LSB 4
`define DCC_POS_LATCH_LSB 2

// Reset values.
`define DCC_CTRL_RST 6'h00
`define DCC_EN_RST 3'h0
`define DCC_DIR_RST 2'h3
`define DCC_LAT_RST 2'h0

`endif

// ---- hdl/dcc_pkg.sv ----
// Types shared by the comparator control block.
package dcc_pkg;

    // Eight comparator operating modes.
    typedef enum logic [2:0] {
        DCC_MODE_RESET = 3'b000,
        DCC_MODE_ONE = 3'b001,
        DCC_MODE_TWO = 3'b010,
        DCC_MODE_TWO_OUT = 3'b011,
        DCC_MODE_COMMON = 3'b100,
        DCC_MODE_COMMON_OUT = 3'b101,
        DCC_MODE_MUX_VREF = 3'b110,
        DCC_MODE_OFF = 3'b111
    } dcc_mode_t;

    // Writable part of comparator_control.
    typedef struct packed {
        logic second_polarity_flip;
        logic first_polarity_flip;
        logic input_switch;
        dcc_mode_t comparator_mode_field;
    } dcc_ctrl_t;

    // APB request from the master.
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } dcc_apb_req_t;

    // APB answer to the master.
    typedef struct packed {
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } dcc_apb_rsp_t;

    // Steering of the analog multiplexers; index 0 is comparator 1.
    typedef struct packed {
        logic [1:0] power;
        logic [3:0] analog_mask;
        logic [1:0] pos_vref;
        logic [1:0] pos1_pin;
        logic [1:0] pos2_pin;
        logic [1:0] neg1_pin;
        logic [1:0] neg2_pin;
        logic out_route;
    } dcc_route_t;

    // Synchroniser state.
    typedef struct packed {
        logic [7:0] meta;
        logic [7:0] stable;
    } dcc_sync_t;

    // Main block state.
    typedef struct packed {
        dcc_ctrl_t ctrl;
        logic [1:0] latched;
        logic flag;
        logic [2:0] en;
        logic [1:0] dir;
        logic [1:0] lat;
        logic ack;
        logic [31:0] rdata;
        logic slverr;
    } dcc_state_t;

endpackage

// ---- hdl/dcc_sync2.sv ----
// Two-stage synchroniser for the asynchronous comparator and pin inputs.
`timescale 1ns/100ps
module dcc_sync2 (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Asynchronous inputs and their synchronised copies.
    input wire logic [7:0] async_in,
    output logic [7:0] sync_out
);
    import dcc_pkg::*;

    dcc_sync_t s_reg;
    dcc_sync_t s_next;

    // The first stage feeds only the second stage.
    always_comb begin
        s_next.meta = async_in;
        s_next.stable = s_reg.meta;
    end

    // Register the state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign sync_out = s_reg.stable;
endmodule // dcc_sync2

// ---- hdl/dcc_top.sv ----
// Control, status and change detection around two analog comparators.
//
// Functional notes
// - Raw result high when plus exceeds minus.
// - Flip bits 5 and 4 invert outputs.
// - Bits 7 and 6 show outputs, read-only.
// - Bits 2 to 0 pick one of eight modes.
// - Mode 110: switch bit picks minus pins.
// - Mode 110: reference feeds both plus inputs.
// - Routed outputs reach pins unsynchronised.
// - Direction bits still gate routed pin drivers.
// - Any output change sets the change flag.
// - Writing zero clears flag, one sets it.
// - Request needs all three enables set.
// - Mismatch re-sets flag until register accessed.
// - Change during read still sets flag.
// - Comparators run in sleep, wake enabled.
// - Mode 111 powers both comparators off.
// - Wake leaves control register unchanged.
// - Reset selects mode 000, comparators off.
// - Analog pins read zero on port read.
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/100ps
`include "dcc_defines.svh"
module dcc_top (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire dcc_pkg::dcc_apb_req_t apb_req,
    output dcc_pkg::dcc_apb_rsp_t apb_rsp,
    // Analog comparator side.
    input wire logic [1:0] raw_result,
    output dcc_pkg::dcc_route_t route,
    // Port pins.
    input wire logic [3:0] pin_d_i,
    input wire logic [1:0] pin_e_i,
    output logic [1:0] pin_e_o,
    output logic [1:0] pin_e_oe,
    // Interrupt and wake requests.
    output logic irq_o,
    output logic wake_o
);
    import dcc_pkg::*;

    dcc_state_t s_reg;
    dcc_state_t s_next;
    logic [7:0] sync_q;
    logic [1:0] res_sync;
    logic [3:0] pin_d_sync;
    logic [1:0] pin_e_sync;
    logic [1:0] flip;
    logic [1:0] status;
    logic [1:0] live_out;
    logic mismatch;
    logic access;
    logic wr;
    logic ctrl_access;

    // Every asynchronous input passes two flops; only the routed pin path also reads raw_result directly.
    dcc_sync2 u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({pin_e_i, pin_d_i, raw_result}),
        .sync_out(sync_q)
    );

    assign res_sync = sync_q[1:0];
    assign pin_d_sync = sync_q[5:2];
    assign pin_e_sync = sync_q[7:6];

    // Mode decode; the table is fixed here so the analog side stays dumb.
    function automatic dcc_route_t decode(input dcc_ctrl_t c);
        dcc_route_t r;
        r = '0;
        r.pos1_pin = 2'h1;
        r.neg1_pin = 2'h0;
        r.pos2_pin = 2'h3;
        r.neg2_pin = 2'h2;
        case (c.comparator_mode_field)
            DCC_MODE_RESET: begin
                r.analog_mask = 4'hf;
            end
            DCC_MODE_ONE: begin
                r.power = 2'h1;
                r.analog_mask = 4'h3;
            end
            DCC_MODE_TWO: begin
                r.power = 2'h3;
                r.analog_mask = 4'hf;
            end
            DCC_MODE_TWO_OUT: begin
                r.power = 2'h3;
                r.analog_mask = 4'hf;
                r.out_route = 1'b1;
            end
            DCC_MODE_COMMON: begin
                r.power = 2'h3;
                r.analog_mask = 4'h7;
                r.pos2_pin = 2'h1;
            end
            DCC_MODE_COMMON_OUT: begin
                r.power = 2'h3;
                r.analog_mask = 4'h7;
                r.pos2_pin = 2'h1;
                r.out_route = 1'b1;
            end
            DCC_MODE_MUX_VREF: begin
                r.power = 2'h3;
                r.analog_mask = 4'hf;
                r.pos_vref = 2'h3;
                r.neg1_pin = c.input_switch ? 2'h0 : 2'h1;
                r.neg2_pin = c.input_switch ? 2'h2 : 2'h3;
            end
            DCC_MODE_OFF: begin
                r.power = 2'h0;
                r.analog_mask = 4'h0;
            end
            default: begin
                r.power = 2'h0;
            end
        endcase
        return r;
    endfunction

    // Comparators stay powered in sleep; only the mode field turns them off.
    assign route = decode(s_reg.ctrl);

    // Polarity flip; a powered-down comparator reads as low.
    assign flip = {s_reg.ctrl.second_polarity_flip, s_reg.ctrl.first_polarity_flip};
    assign status = (res_sync ^ flip) & route.power;
    assign live_out = (raw_result ^ flip) & route.power;

    // Routed pins bypass synchronisation, so glitches near the threshold pass through.
    assign pin_e_o = route.out_route ? live_out : s_reg.lat;
    assign pin_e_oe = ~s_reg.dir;

    // A change against the copy taken at the last control register access is a mismatch.
    assign mismatch = status != s_reg.latched;

    // Requests reach the core only with all enables; wake needs only the source enable.
    assign irq_o = s_reg.flag & (&s_reg.en);
    assign wake_o = s_reg.flag & s_reg.en[`DCC_POS_CHANGE_EN];

    // The access phase takes two cycles: one to prepare read data, one to answer.
    assign access = apb_req.psel & apb_req.penable & s_reg.ack;
    assign wr = access & apb_req.pwrite;
    assign ctrl_access = access & (apb_req.paddr == `DCC_ADDR_CTRL);

    // Answer signals.
    always_comb begin
        apb_rsp.pready = apb_req.psel & apb_req.penable & s_reg.ack;
        apb_rsp.prdata = s_reg.rdata;
        apb_rsp.pslverr = s_reg.slverr & apb_rsp.pready;
    end

    // Next state of the whole block.
    always_comb begin
        s_next = s_reg;
        s_next.ack = 1'b0;
        if (apb_req.psel && apb_req.penable && !s_reg.ack) begin
            s_next.ack = 1'b1;
            s_next.slverr = 1'b0;
            s_next.rdata = 32'h0000_0000;
            case (apb_req.paddr)
                `DCC_ADDR_CTRL: s_next.rdata = {24'h00_0000, status, s_reg.ctrl};
                `DCC_ADDR_FLAG: s_next.rdata = {31'h0000_0000, s_reg.flag};
                `DCC_ADDR_EN: s_next.rdata = {29'h0000_0000, s_reg.en};
                `DCC_ADDR_PORT: s_next.rdata = {26'h000_0000, pin_e_sync,
                    pin_d_sync & ~route.analog_mask};
                `DCC_ADDR_PCFG: s_next.rdata = {28'h000_0000, s_reg.lat, s_reg.dir};
                default: s_next.slverr = 1'b1;
            endcase
        end
        // Bits 7 and 6 are not stored, so writes to them vanish.
        if (wr && apb_req.paddr == `DCC_ADDR_CTRL) begin
            s_next.ctrl = dcc_ctrl_t'(apb_req.pwdata[5:0]);
        end
        if (wr && apb_req.paddr == `DCC_ADDR_EN) begin
            s_next.en = apb_req.pwdata[2:0];
        end
        if (wr && apb_req.paddr == `DCC_ADDR_PCFG) begin
            s_next.dir = apb_req.pwdata[1:0];
            s_next.lat = apb_req.pwdata[3:2];
        end
        // Read or write of the control register ends the mismatch.
        if (ctrl_access) begin
            s_next.latched = status;
        end
        // Software may clear or force the flag.
        if (wr && apb_req.paddr == `DCC_ADDR_FLAG) begin
            s_next.flag = apb_req.pwdata[0];
        end
        // Hardware set wins over a clear in the same cycle.
        if (mismatch) begin
            s_next.flag = 1'b1;
        end
    end

    // Register the state; sleep has no input here, so wake never disturbs it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg.ctrl <= dcc_ctrl_t'(`DCC_CTRL_RST);
            s_reg.latched <= 2'h0;
            s_reg.flag <= 1'b0;
            s_reg.en <= `DCC_EN_RST;
            s_reg.dir <= `DCC_DIR_RST;
            s_reg.lat <= `DCC_LAT_RST;
            s_reg.ack <= 1'b0;
            s_reg.rdata <= 32'h0000_0000;
            s_reg.slverr <= 1'b0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Completed access to the control register.
    sequence seq_ctrl_done;
        apb_rsp.pready && apb_req.paddr == `DCC_ADDR_CTRL;
    endsequence

    // Completed read of the port status register.
    sequence seq_port_read;
        apb_rsp.pready && !apb_req.pwrite && apb_req.paddr == `DCC_ADDR_PORT;
    endsequence

    // Access waits exactly one cycle before the answer.
    AST_APB_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
        apb_req.psel && apb_req.penable && !apb_rsp.pready |=> apb_rsp.pready)
        else $error("APB answer did not follow one wait cycle");

    // Control read returns the flipped outputs seen one cycle earlier.
    AST_STATUS_READ: assert property (@(posedge pclk) disable iff (!presetn)
        seq_ctrl_done ##0 !apb_req.pwrite |->
        apb_rsp.prdata[7:6] == $past(status))
        else $error("Control read shows wrong output bits");

    // Routed pins carry the unsynchronised, flipped comparator output.
    AST_PIN_ROUTE: assert property (@(posedge pclk) disable iff (!presetn)
        route.out_route |-> pin_e_o == ((raw_result ^ flip) & route.power))
        else $error("Routed pin differs from comparator output");

    // Pin drivers follow the direction bits in every mode.
    AST_PIN_OE: assert property (@(posedge pclk) disable iff (!presetn)
        pin_e_oe == ~s_reg.dir)
        else $error("Pin enable ignores direction bits");

    // Mode 110 takes the reference and the switch-selected first minus pin.
    AST_MUX_VREF: assert property (@(posedge pclk) disable iff (!presetn)
        s_reg.ctrl.comparator_mode_field == DCC_MODE_MUX_VREF |->
        route.pos_vref == 2'h3 &&
        route.neg1_pin == (s_reg.ctrl.input_switch ? 2'h0 : 2'h1))
        else $error("Mode 110 routing wrong");

    // A mismatch sets the flag on the next edge, whatever software wrote.
    AST_FLAG_SET: assert property (@(posedge pclk) disable iff (!presetn)
        mismatch |=> s_reg.flag)
        else $error("Change flag not set after mismatch");

    // Request only with flag and all three enables.
    AST_IRQ_GATE: assert property (@(posedge pclk) disable iff (!presetn)
        irq_o == (s_reg.flag && s_reg.en == 3'h7))
        else $error("Interrupt request gating wrong");

    // Access to the control register ends the mismatch on the next edge.
    AST_MISMATCH_END: assert property (@(posedge pclk) disable iff (!presetn)
        seq_ctrl_done ##0 (status == $past(status)) |=>
        s_reg.latched == $past(status))
        else $error("Access did not latch output bits");

    // Software write of zero clears the flag when no mismatch is pending.
    AST_FLAG_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        apb_rsp.pready && apb_req.pwrite && apb_req.paddr == `DCC_ADDR_FLAG &&
        !mismatch |=> s_reg.flag == $past(apb_req.pwdata[0]))
        else $error("Flag write not honoured");

    // Mode 111 keeps both comparators powered down.
    AST_MODE_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        s_reg.ctrl.comparator_mode_field == DCC_MODE_OFF |-> route.power == 2'h0)
        else $error("Comparators powered in mode 111");

    // Analog pins read as zero through the port status register.
    AST_PORT_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        seq_port_read |-> (apb_rsp.prdata[3:0] & $past(route.analog_mask)) == 4'h0)
        else $error("Analog pin read as one");

    // Sleep and wake never touch the control register: only writes change it.
    AST_CTRL_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr && apb_req.paddr == `DCC_ADDR_CTRL) |=> $stable(s_reg.ctrl))
        else $error("Control register changed without a write");

    // Out of reset the comparators are off at the first edge.
    AST_RESET_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> route.power == 2'h0)
        else $error("Comparators powered right after reset");

    // Completed write to the flag register.
    sequence seq_flag_write;
        apb_rsp.pready && apb_req.pwrite && apb_req.paddr == `DCC_ADDR_FLAG;
    endsequence

    // Wake follows the flag and the source enable alone.
    AST_WAKE_GATE: assert property (@(posedge pclk) disable iff (!presetn)
        wake_o == (s_reg.flag && s_reg.en[`DCC_POS_CHANGE_EN]))
        else $error("Wake request gating wrong");

    // Mode 110 switches the second minus pin with the input switch bit.
    AST_MUX_NEG2: assert property (@(posedge pclk) disable iff (!presetn)
        s_reg.ctrl.comparator_mode_field == DCC_MODE_MUX_VREF |->
        route.neg2_pin == (s_reg.ctrl.input_switch ? 2'h2 : 2'h3))
        else $error("Mode 110 second minus pin wrong");

    // Out of reset the mode is 000 with every comparator pin analog.
    AST_RESET_MODE: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(presetn) |->
        s_reg.ctrl == dcc_ctrl_t'(`DCC_CTRL_RST) && route.analog_mask == 4'hf)
        else $error("Reset did not select mode 000");

    // A control write keeps only the writable bits; the status bits are not stored.
    AST_RESULT_RO: assert property (@(posedge pclk) disable iff (!presetn)
        seq_ctrl_done ##0 apb_req.pwrite |=> s_reg.ctrl == dcc_ctrl_t'($past(apb_req.pwdata[5:0])))
        else $error("Control write not taken");

    // Without a mismatch or a flag write the flag holds its value.
    AST_FLAG_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        !mismatch && !(wr && apb_req.paddr == `DCC_ADDR_FLAG) |=> $stable(s_reg.flag))
        else $error("Change flag moved on its own");

    // Software writing one forces the flag.
    AST_FLAG_FORCE: assert property (@(posedge pclk) disable iff (!presetn)
        seq_flag_write ##0 apb_req.pwdata[0] |=> s_reg.flag)
        else $error("Flag write of one ignored");

    // Only a control access moves the latched copy, so a mismatch persists until then.
    AST_LATCH_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_access |=> $stable(s_reg.latched))
        else $error("Latched outputs moved without access");

    // With both comparators powered down, status always reports low.
    AST_POWER_LOW: assert property (@(posedge pclk) disable iff (!presetn)
        route.power == 2'h0 |-> status == 2'h0)
        else $error("Powered-down comparator reports high");

endmodule // dcc_top

// ---- dv/dcc_analog_model.sv ----
// Behavioural model of the comparator analog front end and the port d pins.
`timescale 1ns/100ps
module dcc_analog_model (
    // Multiplexer steering from the block.
    input wire dcc_pkg::dcc_route_t route,
    // Pin levels d3..d0 as 8-bit voltages, and the on-chip reference.
    input wire logic [31:0] pin_volts,
    input wire logic [7:0] vref,
    // Comparator results and digital pin levels.
    output logic [1:0] raw_result,
    output logic [3:0] pin_d
);
    import dcc_pkg::*;
    logic [7:0] plus_v [2];
    logic [7:0] minus_v [2];

    // Each comparator sees the pins its multiplexers pick; the reference overrides the plus pin.
    always_comb begin
        plus_v[0] = route.pos_vref[0] ? vref : pin_volts[8*route.pos1_pin +: 8];
        plus_v[1] = route.pos_vref[1] ? vref : pin_volts[8*route.pos2_pin +: 8];
        minus_v[0] = pin_volts[8*route.neg1_pin +: 8];
        minus_v[1] = pin_volts[8*route.neg2_pin +: 8];
        // An unpowered comparator gives a low output, so no stale result survives power-down.
        for (int i = 0; i < 2; i++) begin
            raw_result[i] = route.power[i] & (plus_v[i] > minus_v[i]);
        end
        // Digital threshold at half scale; the stimulus never sits on the threshold.
        for (int i = 0; i < 4; i++) begin
            pin_d[i] = pin_volts[8*i+7];
        end
    end
endmodule // dcc_analog_model

// ---- dv/dcc_top_tb.sv ----
// Self-checking testbench of the comparator control block.
`timescale 1ns/100ps
`include "dcc_defines.svh"
module dcc_top_tb;
    import dcc_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    dcc_apb_req_t apb_req = '0;
    dcc_apb_rsp_t apb_rsp;
    dcc_route_t route;
    logic [1:0] raw_result;
    logic [3:0] pin_d_i;
    logic [1:0] pin_e_i;
    logic [1:0] pin_e_o;
    logic [1:0] pin_e_oe;
    logic irq_o;
    logic wake_o;
    logic [31:0] pin_volts = '0;
    logic [7:0] vref = 8'h80;
    int mismatches = 0;
    int check_count = 0;

    // Clock of 8 ns period.
    always #4 pclk = ~pclk;

    // A released port e pin has no pull, so it shows the inverse of its drive value.
    assign pin_e_i = pin_e_o ^ ~pin_e_oe;

    dcc_top dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .raw_result(raw_result), .route(route), .pin_d_i(pin_d_i), .pin_e_i(pin_e_i),
        .pin_e_o(pin_e_o), .pin_e_oe(pin_e_oe), .irq_o(irq_o), .wake_o(wake_o));

    dcc_analog_model analog (.route(route), .pin_volts(pin_volts), .vref(vref),
        .raw_result(raw_result), .pin_d(pin_d_i));

    // Verdict and end of run.
    task automatic complete_run();
        if (mismatches == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One APB transfer; pready and read data are taken at the rising edge that commits it.
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 16);
        if (apb_rsp.pready !== 1'b1) begin
            check("pready", 32'h1, 32'(apb_rsp.pready));
            complete_run();
        end
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        // Callers look at outputs only after the committed state has settled.
        #1;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(a, 1'b1, d, r, e);
    endtask

    task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(a, 1'b0, 32'h0, r, e);
        check(name, exp, r);
    endtask

    // Pin voltages change at an edge; status follows after the two-flop synchroniser.
    task automatic set_v(input logic [31:0] v);
        @(posedge pclk);
        pin_volts <= v;
        repeat (3) @(posedge pclk);
    endtask

    task automatic t_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        check("power", 32'h0, 32'(route.power));
        check("analog_mask", 32'hf, 32'(route.analog_mask));
        check("pin_e_oe", 32'h0, 32'(pin_e_oe));
        presetn <= 1'b1;
        rd_chk("ctrl", `DCC_ADDR_CTRL, 32'h0);
        rd_chk("en", `DCC_ADDR_EN, 32'h0);
    endtask

    task automatic t_modes();
        logic [1:0] pw [8] = '{2'b00, 2'b01, 2'b11, 2'b11, 2'b11, 2'b11, 2'b11, 2'b00};
        for (int m = 0; m < 8; m++) begin
            wr(`DCC_ADDR_CTRL, 32'(m));
            check("power", 32'(pw[m]), 32'(route.power));
            check("out_route", 32'(m == 3 || m == 5), 32'(route.out_route));
        end
        check("analog_mask", 32'h0, 32'(route.analog_mask));
    endtask

    // Status bits are read-only and follow the flip bits; unmapped places are refused.
    task automatic t_polarity();
        logic [31:0] r;
        logic e;
        set_v(32'h0000_9000);
        for (int f = 0; f < 4; f++) begin
            wr(`DCC_ADDR_CTRL, 32'hc2 | 32'(f << 4));
            repeat (3) @(posedge pclk);
            rd_chk("ctrl", `DCC_ADDR_CTRL, 32'({f[1], ~f[0], f[1:0], 4'h2}));
        end
        apb(12'h020, 1'b0, 32'h0, r, e);
        check("pslverr", 32'h1, 32'(e));
        check("prdata", 32'h0, r);
    endtask

    task automatic t_mux();
        set_v(32'h10f0_f010);
        for (int s = 0; s < 2; s++) begin
            wr(`DCC_ADDR_CTRL, 32'h6 | 32'(s << 3));
            check("pos_vref", 32'h3, 32'(route.pos_vref));
            check("neg1_pin", s ? 32'h0 : 32'h1, 32'(route.neg1_pin));
            check("neg2_pin", s ? 32'h2 : 32'h3, 32'(route.neg2_pin));
            repeat (3) @(posedge pclk);
            rd_chk("ctrl", `DCC_ADDR_CTRL, s ? 32'h4e : 32'h86);
        end
    endtask

    // Routed outputs follow the comparators within a cycle; direction still gates drivers.
    task automatic t_route();
        set_v(32'h0000_9000);
        wr(`DCC_ADDR_PCFG, 32'h2);
        wr(`DCC_ADDR_CTRL, 32'h3);
        check("pin_e_oe", 32'h1, 32'(pin_e_oe));
        check("pin_e_o", 32'h1, 32'(pin_e_o));
        @(posedge pclk);
        pin_volts <= 32'h9000_9000;
        #2;
        check("pin_e_o", 32'h3, 32'(pin_e_o));
        wr(`DCC_ADDR_CTRL, 32'h23);
        check("pin_e_o", 32'h1, 32'(pin_e_o));
        wr(`DCC_ADDR_PCFG, 32'h1);
        check("pin_e_oe", 32'h2, 32'(pin_e_oe));
    endtask

    task automatic t_flag();
        int n;
        wr(`DCC_ADDR_EN, 32'h0);
        wr(`DCC_ADDR_CTRL, 32'h2);
        set_v(32'h0);
        rd_chk("ctrl", `DCC_ADDR_CTRL, 32'h2);
        wr(`DCC_ADDR_FLAG, 32'h0);
        wr(`DCC_ADDR_EN, 32'h7);
        check("irq", 32'h0, 32'(irq_o));
        @(posedge pclk);
        pin_volts <= 32'h0000_9000;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (irq_o !== 1'b1 && n < 8);
        check("irq", 32'h1, 32'(irq_o));
        if (irq_o !== 1'b1) begin
            complete_run();
        end
        check("wake", 32'h1, 32'(wake_o));
        // A clear without a control access loses to the pending mismatch.
        wr(`DCC_ADDR_FLAG, 32'h0);
        rd_chk("flag", `DCC_ADDR_FLAG, 32'h1);
        rd_chk("ctrl", `DCC_ADDR_CTRL, 32'h42);
        wr(`DCC_ADDR_FLAG, 32'h0);
        rd_chk("flag", `DCC_ADDR_FLAG, 32'h0);
        check("irq", 32'h0, 32'(irq_o));
        wr(`DCC_ADDR_EN, 32'h3);
        wr(`DCC_ADDR_FLAG, 32'h1);
        rd_chk("flag", `DCC_ADDR_FLAG, 32'h1);
        check("irq", 32'h0, 32'(irq_o));
        check("wake", 32'h1, 32'(wake_o));
        wr(`DCC_ADDR_EN, 32'h6);
        check("wake", 32'h0, 32'(wake_o));
        check("irq", 32'h0, 32'(irq_o));
        wr(`DCC_ADDR_FLAG, 32'h0);
    endtask

    task automatic t_port();
        logic [31:0] r;
        logic e;
        wr(`DCC_ADDR_CTRL, 32'h0);
        set_v(32'hffff_ffff);
        apb(`DCC_ADDR_PORT, 1'b0, 32'h0, r, e);
        check("port_d", 32'h0, 32'(r[3:0]));
        check("port_e", 32'h1, 32'(r[5:4]));
        wr(`DCC_ADDR_CTRL, 32'h7);
        repeat (3) @(posedge pclk);
        apb(`DCC_ADDR_PORT, 1'b0, 32'h0, r, e);
        check("port_d", 32'hf, 32'(r[3:0]));
    endtask

    // Main sequence, ending with a reset in mid-run.
    initial begin
        t_reset();
        t_modes();
        t_polarity();
        t_mux();
        t_route();
        t_flag();
        t_port();
        t_reset();
        complete_run();
    end
endmodule // dcc_top_tb
